// [clkbuf_cfg_pkg.sv]
// Constants for the clock buffer configuration registers and SMBus port.
// Assumes SCL and SDA arrive already synchronous to the system clock.
// Operation
// R1: Control bit 5 enables software frequency changes, reset 0.
// R2: Control bits 4:3 select frequency, reset 0, effective only if enabled.
// R3: Control bit 0 sets feedback edge rate: 0 slow, 1 fast; reset 1.
// R4: Reserved index 4 always reads all ones.
// R5: Index 5 read-only: revision code high nibble, vendor code low nibble.
// R6: Index 6 is read-only: two-bit variant code over six-bit part code.
// R7: Index 7 bits 4:0 hold readback length, reset 8; bits 7:5 read 0.
// R8: Block read sends the length byte first, then bytes from the index.
// R9: Host acks each byte read, sends not-ack after the last, then stops.
// R10: Writes to read-only or reserved bits never change what reads return.
package clkbuf_cfg_pkg;
	localparam logic [7:0] IDX_FREQ_CTRL = 8'h03;
	localparam logic [7:0] IDX_RSVD_ONES = 8'h04;
	localparam logic [7:0] IDX_REV_VENDOR = 8'h05;
	localparam logic [7:0] IDX_TYPE_PART = 8'h06;
	localparam logic [7:0] IDX_READBACK_LEN = 8'h07;
	localparam int BIT_FREQ_EN = 5;
	localparam int BIT_FREQ_HI = 4;
	localparam int BIT_FREQ_LO = 3;
	localparam int BIT_EDGE_RATE = 0;
	localparam logic RST_FREQ_EN = 1'b0;
	localparam logic [1:0] RST_FREQ_CHOICE = 2'h0;
	localparam logic RST_EDGE_RATE = 1'b1;
	localparam logic [4:0] RST_READBACK_LEN = 5'h08;
	localparam logic [1:0] FREQ_CTRL_RSVD_HI = 2'h0;
	localparam logic [1:0] FREQ_CTRL_RSVD_LO = 2'h3;
	localparam logic [7:0] RSVD_ALL_ONES = 8'hff;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic [7:0] PAST_LENGTH_FILL = 8'hff;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// Arbitrary identity values
	localparam logic [3:0] REVISION_CODE = 4'h3;
	localparam logic [3:0] VENDOR_CODE = 4'h5;
	localparam logic [1:0] VARIANT_CODE = 2'h3;
	localparam logic [5:0] PART_CODE = 6'h2a;
	localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h10;
endpackage

// [reg_port_if.sv]
// Register access path between the SMBus engine and the register bank.
// Assumes one clock domain; write strobe is a one-cycle pulse.
`timescale 1ns/1ns
interface reg_port_if;
	logic [7:0] idx;
	logic wr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [4:0] readback_len;
	modport engine (output idx, output wr, output wdata,
		input rdata, input readback_len);
	modport bank (input idx, input wr, input wdata,
		output rdata, output readback_len);
endinterface

// [cfg_reg_bank.sv]
// Register bank for bytes 3 to 7 of the configuration space.
// Assumes writes arrive as single-cycle strobes from the SMBus engine.
`timescale 1ns/1ns
module cfg_reg_bank (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	reg_port_if.bank rp,
	output logic o_freq_sel_en,
	output logic [1:0] o_freq_choice,
	output logic o_feedback_edge_rate_select
);
	typedef struct packed {
		logic freq_en;
		logic [1:0] freq_choice;
		logic edge_rate;
		logic [4:0] readback_len;
	} bank_s;

	localparam bank_s BANK_RESET = '{freq_en: clkbuf_cfg_pkg::RST_FREQ_EN,
		freq_choice: clkbuf_cfg_pkg::RST_FREQ_CHOICE,
		edge_rate: clkbuf_cfg_pkg::RST_EDGE_RATE,
		readback_len: clkbuf_cfg_pkg::RST_READBACK_LEN};

	bank_s st;
	bank_s next_st;

	always_comb
	begin
		next_st = st;
		if (rp.wr && rp.idx == clkbuf_cfg_pkg::IDX_FREQ_CTRL)
		begin
			next_st.freq_en = rp.wdata[clkbuf_cfg_pkg::BIT_FREQ_EN]; // [R1]
			next_st.freq_choice = {rp.wdata[clkbuf_cfg_pkg::BIT_FREQ_HI],
				rp.wdata[clkbuf_cfg_pkg::BIT_FREQ_LO]}; // [R2]
			next_st.edge_rate = rp.wdata[clkbuf_cfg_pkg::BIT_EDGE_RATE]; // [R3]
		end
		if (rp.wr && rp.idx == clkbuf_cfg_pkg::IDX_READBACK_LEN)
			next_st.readback_len = rp.wdata[4:0]; // [R7]
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
			st <= BANK_RESET;
		else
			st <= next_st;
	end

	// Reserved and identity bytes are constants, so writes cannot reach them
	always_comb
	begin
		case (rp.idx)
			clkbuf_cfg_pkg::IDX_FREQ_CTRL: rp.rdata = {
				clkbuf_cfg_pkg::FREQ_CTRL_RSVD_HI, st.freq_en, st.freq_choice,
				clkbuf_cfg_pkg::FREQ_CTRL_RSVD_LO, st.edge_rate}; // [R10]
			clkbuf_cfg_pkg::IDX_RSVD_ONES:
				rp.rdata = clkbuf_cfg_pkg::RSVD_ALL_ONES; // [R4]
			clkbuf_cfg_pkg::IDX_REV_VENDOR: rp.rdata = {
				clkbuf_cfg_pkg::REVISION_CODE, clkbuf_cfg_pkg::VENDOR_CODE}; // [R5]
			clkbuf_cfg_pkg::IDX_TYPE_PART: rp.rdata = {
				clkbuf_cfg_pkg::VARIANT_CODE, clkbuf_cfg_pkg::PART_CODE}; // [R6]
			clkbuf_cfg_pkg::IDX_READBACK_LEN:
				rp.rdata = {3'h0, st.readback_len}; // [R7]
			default: rp.rdata = clkbuf_cfg_pkg::UNMAPPED_READ;
		endcase
	end

	assign rp.readback_len = st.readback_len;
	assign o_freq_sel_en = st.freq_en;
	// Choice is held at zero while software control is off
	assign o_freq_choice = st.freq_en ? st.freq_choice : 2'h0; // [R2]
	assign o_feedback_edge_rate_select = st.edge_rate;

	a_freq_en_write: assert property (@(posedge i_clk_sys) // [R1]
		disable iff (!i_rst_b)
		rp.wr && rp.idx == clkbuf_cfg_pkg::IDX_FREQ_CTRL
		|=> o_freq_sel_en == $past(rp.wdata[5]))
		else $error("frequency enable did not follow write");
	a_choice_gated: assert property (@(posedge i_clk_sys) // [R2]
		disable iff (!i_rst_b)
		!o_freq_sel_en |-> o_freq_choice == 2'h0)
		else $error("frequency choice active while disabled");
	a_edge_rate_write: assert property (@(posedge i_clk_sys) // [R3]
		disable iff (!i_rst_b)
		rp.wr && rp.idx == clkbuf_cfg_pkg::IDX_FREQ_CTRL
		|=> o_feedback_edge_rate_select == $past(rp.wdata[0]))
		else $error("edge rate did not follow write");
	a_rsvd_all_ones: assert property (@(posedge i_clk_sys) // [R4]
		disable iff (!i_rst_b)
		rp.idx == clkbuf_cfg_pkg::IDX_RSVD_ONES |-> rp.rdata == 8'hff)
		else $error("reserved byte not all ones");
	a_ident_fixed: assert property (@(posedge i_clk_sys) // [R5]
		disable iff (!i_rst_b)
		rp.idx == clkbuf_cfg_pkg::IDX_REV_VENDOR |-> rp.rdata == 8'h35)
		else $error("revision and vendor byte wrong");
	a_part_fixed: assert property (@(posedge i_clk_sys) // [R6]
		disable iff (!i_rst_b)
		rp.idx == clkbuf_cfg_pkg::IDX_TYPE_PART |-> rp.rdata == 8'hea)
		else $error("variant and part byte wrong");
	a_len_write: assert property (@(posedge i_clk_sys) // [R7]
		disable iff (!i_rst_b)
		rp.wr && rp.idx == clkbuf_cfg_pkg::IDX_READBACK_LEN
		|=> rp.readback_len == $past(rp.wdata[4:0]))
		else $error("readback length did not follow write");
	// Index moves on after every write, so state is watched, not read data
	a_ro_unchanged: assert property (@(posedge i_clk_sys) // [R10]
		disable iff (!i_rst_b)
		rp.wr && rp.idx >= clkbuf_cfg_pkg::IDX_RSVD_ONES
		&& rp.idx <= clkbuf_cfg_pkg::IDX_TYPE_PART |=> $stable(st))
		else $error("write to a read-only byte changed state");
	a_rsvd_bits_fixed: assert property (@(posedge i_clk_sys) // [R10]
		disable iff (!i_rst_b)
		rp.idx == clkbuf_cfg_pkg::IDX_FREQ_CTRL
		|-> rp.rdata[7:6] == 2'h0 && rp.rdata[2:1] == 2'h3)
		else $error("reserved control bits changed");
	a_len_upper_zero: assert property (@(posedge i_clk_sys) // [R7]
		disable iff (!i_rst_b)
		rp.idx == clkbuf_cfg_pkg::IDX_READBACK_LEN |-> rp.rdata[7:5] == 3'h0)
		else $error("reserved length bits not zero");
endmodule

// [clkbuf_cfg_smbus.sv]
// SMBus slave with indexed block read and write over the config bank.
// Assumes SCL and SDA are sampled synchronously; SDA is open drain.
`timescale 1ns/1ns
module clkbuf_cfg_smbus #(
	parameter logic [6:0] SLAVE_ADDR = clkbuf_cfg_pkg::DEFAULT_SLAVE_ADDR
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	output logic o_freq_sel_en,
	output logic [1:0] o_freq_choice,
	output logic o_feedback_edge_rate_select
);
	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK, S_WLEN, S_WLEN_ACK,
		S_WDATA, S_WDATA_ACK, S_TX, S_TX_ACK
	} phase_e;

	typedef struct packed {
		phase_e phase;
		logic scl_q;
		logic sda_q;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic rd;
		logic [7:0] idx;
		logic [7:0] left;
		logic sda_low;
	} eng_s;

	localparam eng_s ENG_RESET = '{phase: S_IDLE, scl_q: 1'b1, sda_q: 1'b1,
		bitcnt: 4'h0, shreg: 8'h00, rd: 1'b0, idx: 8'h00, left: 8'h00,
		sda_low: 1'b0};

	eng_s st;
	eng_s next_st;
	reg_port_if rp ();

	logic rise;
	logic fall;
	logic start_cond;
	logic stop_cond;
	logic byte_done;

	assign rise = i_scl && !st.scl_q;
	assign fall = !i_scl && st.scl_q;
	assign start_cond = i_scl && st.scl_q && st.sda_q && !i_sda;
	assign stop_cond = i_scl && st.scl_q && !st.sda_q && i_sda;
	assign byte_done = fall && st.bitcnt == clkbuf_cfg_pkg::BITS_PER_BYTE;

	always_comb
	begin
		next_st = st;
		rp.wr = 1'b0;
		next_st.scl_q = i_scl;
		next_st.sda_q = i_sda;
		if (start_cond)
		begin
			// Repeated start lands here too, keeping the stored index
			next_st.phase = S_ADDR;
			next_st.bitcnt = 4'h0;
			next_st.sda_low = 1'b0;
		end
		else if (stop_cond)
		begin
			next_st.phase = S_IDLE;
			next_st.sda_low = 1'b0;
		end
		else
		begin
			case (st.phase)
				S_IDLE: ;
				S_ADDR, S_CMD, S_WLEN, S_WDATA:
				begin
					if (rise)
					begin
						next_st.shreg = {st.shreg[6:0], i_sda};
						next_st.bitcnt = st.bitcnt + 4'h1;
					end
					else if (byte_done)
					begin
						next_st.bitcnt = 4'h0;
						case (st.phase)
							S_ADDR:
								if (st.shreg[7:1] == SLAVE_ADDR)
								begin
									next_st.rd = st.shreg[0];
									next_st.sda_low = 1'b1;
									next_st.phase = S_ADDR_ACK;
								end
								else
									next_st.phase = S_IDLE;
							S_CMD:
							begin
								next_st.idx = st.shreg;
								next_st.sda_low = 1'b1;
								next_st.phase = S_CMD_ACK;
							end
							S_WLEN:
							begin
								next_st.left = st.shreg;
								next_st.sda_low = 1'b1;
								next_st.phase = S_WLEN_ACK;
							end
							default:
								// Bytes past the announced length are refused
								if (st.left != 8'h00)
								begin
									rp.wr = 1'b1;
									next_st.idx = st.idx + 8'h01;
									next_st.left = st.left - 8'h01;
									next_st.sda_low = 1'b1;
									next_st.phase = S_WDATA_ACK;
								end
								else
									next_st.phase = S_IDLE;
						endcase
					end
				end
				S_CMD_ACK, S_WLEN_ACK, S_WDATA_ACK:
					if (fall)
					begin
						next_st.sda_low = 1'b0;
						next_st.phase = (st.phase == S_CMD_ACK) ? S_WLEN : S_WDATA;
					end
				S_ADDR_ACK:
					if (fall)
					begin
						if (st.rd)
						begin
							next_st.shreg = {3'h0, rp.readback_len}; // [R8]
							next_st.left = {3'h0, rp.readback_len}; // [R7]
							next_st.sda_low = ~next_st.shreg[7];
							next_st.bitcnt = 4'h1;
							next_st.phase = S_TX;
						end
						else
						begin
							next_st.sda_low = 1'b0;
							next_st.phase = S_CMD;
						end
					end
				S_TX:
					if (fall)
					begin
						if (st.bitcnt == clkbuf_cfg_pkg::BITS_PER_BYTE)
						begin
							next_st.sda_low = 1'b0;
							next_st.phase = S_TX_ACK;
						end
						else
						begin
							next_st.sda_low = ~st.shreg[6];
							next_st.shreg = {st.shreg[6:0], 1'b0};
							next_st.bitcnt = st.bitcnt + 4'h1;
						end
					end
				S_TX_ACK:
					if (rise && i_sda)
						next_st.phase = S_IDLE; // [R9]
					else if (fall)
					begin
						// Beyond the programmed length the line idles high
						if (st.left != 8'h00)
						begin
							next_st.shreg = rp.rdata; // [R8]
							next_st.idx = st.idx + 8'h01;
							next_st.left = st.left - 8'h01;
						end
						else
							next_st.shreg = clkbuf_cfg_pkg::PAST_LENGTH_FILL;
						next_st.sda_low = ~next_st.shreg[7];
						next_st.bitcnt = 4'h1;
						next_st.phase = S_TX;
					end
				default: next_st = ENG_RESET;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
			st <= ENG_RESET;
		else
			st <= next_st;
	end

	assign rp.idx = st.idx;
	assign rp.wdata = st.shreg;
	assign o_sda = 1'b0;
	assign o_sda_oe = st.sda_low;

	cfg_reg_bank u_bank (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.rp(rp.bank),
		.o_freq_sel_en(o_freq_sel_en),
		.o_freq_choice(o_freq_choice),
		.o_feedback_edge_rate_select(o_feedback_edge_rate_select)
	);

	a_addr_ack_drive: assert property (@(posedge i_clk_sys) // [R8]
		disable iff (!i_rst_b)
		st.phase == S_ADDR && byte_done && !start_cond && !stop_cond
		&& st.shreg[7:1] == SLAVE_ADDR |=> o_sda_oe && st.phase == S_ADDR_ACK)
		else $error("address not acknowledged");
	a_len_first: assert property (@(posedge i_clk_sys) // [R8]
		disable iff (!i_rst_b)
		st.phase == S_ADDR_ACK && st.rd && fall && !start_cond && !stop_cond
		|=> st.phase == S_TX && st.shreg == {3'h0, $past(rp.readback_len)})
		else $error("block read did not start with length");
	a_nack_ends: assert property (@(posedge i_clk_sys) // [R9]
		disable iff (!i_rst_b)
		st.phase == S_TX_ACK && rise && i_sda && !stop_cond
		|=> st.phase == S_IDLE ##1 !o_sda_oe)
		else $error("not-acknowledge did not end read");
	a_stop_release: assert property (@(posedge i_clk_sys) // [R9]
		disable iff (!i_rst_b)
		stop_cond && !start_cond |=> st.phase == S_IDLE && !o_sda_oe)
		else $error("stop did not release bus");
	a_tx_release: assert property (@(posedge i_clk_sys) // [R9]
		disable iff (!i_rst_b)
		st.phase == S_TX_ACK |-> !o_sda_oe)
		else $error("device drove SDA in host ack slot");
endmodule

// [smbus_host_model.sv]
// SMBus host that drives clock and data for the configuration port.
// Assumes a pull-up resolves SDA outside; all changes land at clock edges.
`timescale 1ns/1ns
module smbus_host_model (
	input wire logic i_clk_sys,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	// Data moves mid low phase only, so it never mimics start or stop
	task automatic send_bit(input logic b);
		tick(2);
		o_sda <= b;
		tick(2);
		o_scl <= 1'b1;
		tick(4);
		o_scl <= 1'b0;
	endtask
	task automatic take_bit(output logic b);
		tick(2);
		o_sda <= 1'b1;
		tick(2);
		o_scl <= 1'b1;
		tick(2);
		b = i_sda;
		tick(2);
		o_scl <= 1'b0;
	endtask
	// Also serves as repeated start from a low clock
	task automatic start_cond();
		tick(2);
		o_sda <= 1'b1;
		tick(2);
		o_scl <= 1'b1;
		tick(4);
		o_sda <= 1'b0;
		tick(4);
		o_scl <= 1'b0;
	endtask
	task automatic stop_cond();
		tick(2);
		o_sda <= 1'b0;
		tick(2);
		o_scl <= 1'b1;
		tick(4);
		o_sda <= 1'b1;
		tick(4);
	endtask
	task automatic put_byte(input logic [7:0] v, output logic nak);
		for (int i = 7; i >= 0; i--)
			send_bit(v[i]);
		take_bit(nak);
	endtask
	task automatic get_byte(output logic [7:0] v, input logic last);
		for (int i = 7; i >= 0; i--)
			take_bit(v[i]);
		send_bit(last);
	endtask
endmodule

// [clock_buffer_config_registers_test.sv]
// Self-checking bench: register image model against block reads.
// Assumes the host model and a pull-up on the shared data wire.
`timescale 1ns/1ns
module clock_buffer_config_registers_test;
	localparam logic [6:0] ADDR = 7'h10;
	logic i_clk_sys, i_rst_b, scl, host_sda, sda_val, sda_oe, sda_wire;
	logic en, edge_rate, nak;
	logic [1:0] choice;
	logic [7:0] mdl [8];
	logic [7:0] q [$];
	int fail_count, num_checks, seed;
	// Pull-up: low whenever either side pulls
	assign sda_wire = host_sda & ~(sda_oe & ~sda_val);
	clkbuf_cfg_smbus #(.SLAVE_ADDR(ADDR)) dut (.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda_wire), .o_sda(sda_val),
		.o_sda_oe(sda_oe), .o_freq_sel_en(en), .o_freq_choice(choice),
		.o_feedback_edge_rate_select(edge_rate));
	smbus_host_model host (.i_clk_sys(i_clk_sys), .i_sda(sda_wire),
		.o_scl(scl), .o_sda(host_sda));
	initial
	begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] exp_rd(input int idx);
		case (idx)
			3: return {2'h0, mdl[3][5:3], 2'h3, mdl[3][0]};
			4: return 8'hff;
			5: return {clkbuf_cfg_pkg::REVISION_CODE, clkbuf_cfg_pkg::VENDOR_CODE};
			6: return {clkbuf_cfg_pkg::VARIANT_CODE, clkbuf_cfg_pkg::PART_CODE};
			7: return {3'h0, mdl[7][4:0]};
			default: return 8'h00;
		endcase
	endfunction
	task automatic chk_pins();
		chk({5'h0, en, choice}, {5'h0, mdl[3][5],
			mdl[3][5] ? mdl[3][4:3] : 2'h0});
		chk({7'h0, edge_rate}, {7'h0, mdl[3][0]});
	endtask
	task automatic wr_block(input int idx, input int cnt);
		host.start_cond();
		host.put_byte({ADDR, 1'b0}, nak);
		chk({7'h0, nak}, 8'h00);
		host.put_byte(8'(idx), nak);
		chk({7'h0, nak}, 8'h00);
		host.put_byte(8'(cnt), nak);
		chk({7'h0, nak}, 8'h00);
		foreach (q[i])
		begin
			host.put_byte(q[i], nak);
			chk({7'h0, nak}, {7'h0, i >= cnt});
			if (i < cnt && (idx + i == 3 || idx + i == 7))
				mdl[idx + i] = q[i];
		end
		host.stop_cond();
	endtask
	task automatic rd_block(input int idx, input int n);
		logic [7:0] b;
		host.start_cond();
		host.put_byte({ADDR, 1'b0}, nak);
		host.put_byte(8'(idx), nak);
		host.start_cond();
		host.put_byte({ADDR, 1'b1}, nak);
		chk({7'h0, nak}, 8'h00);
		host.get_byte(b, n == 0);
		chk(b, {3'h0, mdl[7][4:0]});
		for (int i = 0; i < n; i++)
		begin
			host.get_byte(b, i == n - 1);
			chk(b, i < mdl[7][4:0] ? exp_rd(idx + i) : 8'hff);
		end
		host.stop_cond();
	endtask
	initial
	begin
		repeat (60000) @(posedge i_clk_sys);
		fail_count++;
		give_verdict();
	end
	initial
	begin
		seed = 32'h78bd;
		i_rst_b = 1'b0;
		mdl[3] = 8'h01;
		mdl[7] = 8'h08;
		repeat (3) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		chk_pins();
		rd_block(3, 9);
		$display("test reset values done");
		host.start_cond();
		host.put_byte({ADDR ^ 7'h01, 1'b0}, nak);
		chk({7'h0, nak}, 8'h01);
		host.stop_cond();
		$display("test foreign address done");
		// Sixth byte lies past the count and must be refused
		for (int k = 0; k < 4; k++)
		begin
			q = {};
			repeat (6) q.push_back(8'($random(seed)));
			q[0][5] = k[0];
			wr_block(3, 5);
			chk_pins();
			rd_block(k, mdl[7][4:0] + 1);
			$display("test random write %0d done", k);
		end
		give_verdict();
	end
endmodule
